/* verilog/pdt_pkg.sv */
/*
  Shared constants and types for the parameter-default and pod supervision block.
  Assumes a single 25 MHz instrument clock.
*/
`default_nettype none
package pdt_pkg;
  // ---------------------------------------------------------------
  // timing
  // ---------------------------------------------------------------
  localparam int unsigned CLK_PERIOD_NS = 40;
  localparam int unsigned HS_TIMEOUT_NS = 1000000;
  // longest wait per handshake step, rounded down
  localparam int unsigned HS_TIMEOUT_CYC = HS_TIMEOUT_NS / CLK_PERIOD_NS;
  localparam int unsigned RST_WAIT_NS = 200000;
  localparam int unsigned RST_WAIT_CYC = RST_WAIT_NS / CLK_PERIOD_NS;
  // ---------------------------------------------------------------
  // pod command bytes and lengths
  // ---------------------------------------------------------------
  localparam logic [7:0] OP_READ = 8'h01;
  localparam logic [7:0] OP_WRITE = 8'h02;
  localparam logic [7:0] OP_SIG = 8'h03;
  localparam logic [2:0] CMD_LEN_SHORT = 3'h3;
  localparam logic [2:0] CMD_LEN_LONG = 3'h5;
  localparam logic [2:0] RSP_LEN_SHORT = 3'h1;
  localparam logic [2:0] RSP_LEN_LONG = 3'h3;
  localparam int unsigned ST_SYS_BIT = 0;
  // ---------------------------------------------------------------
  // parameter counts per action and reset values
  // ---------------------------------------------------------------
  localparam logic [1:0] NPARAM_READ = 2'h1;
  localparam logic [1:0] NPARAM_WRITE = 2'h2;
  localparam logic [1:0] NPARAM_SIG = 2'h3;
  localparam logic [15:0] LAST_ADDR_RST = 16'h0000;
  localparam logic [15:0] WR_DATA_RST = 16'h0000;
  typedef enum logic [1:0] {PDT_ACT_READ, PDT_ACT_WRITE, PDT_ACT_SIG} pdt_act_t;
  typedef enum logic [1:0] {PDT_FAIL_NONE, PDT_FAIL_TIMEOUT, PDT_FAIL_SYSTEM, PDT_FAIL_TEST} pdt_fail_t;
  typedef enum logic [1:0] {PDT_TO_NONE, PDT_TO_POD, PDT_TO_POWER, PDT_TO_RESET} pdt_to_t;
endpackage
`default_nettype wire

/* verilog/pdt_hs_if.sv */
/*
  Byte request/answer carrier between the controller and the handshake engine.
  Assumes both ends share clk_i.
*/
`default_nettype none
interface pdt_hs_if;
  logic tx_go;
  logic rx_go;
  logic abort;
  logic [7:0] tx_byte;
  logic [7:0] rx_byte;
  logic done;
  logic timeout;
  modport ctl (output tx_go, output rx_go, output abort, output tx_byte,
               input rx_byte, input done, input timeout);
  modport eng (input tx_go, input rx_go, input abort, input tx_byte,
               output rx_byte, output done, output timeout);
endinterface
`default_nettype wire

/* verilog/pdt_hs.sv */
/*
  Four-phase byte handshake engine toward the pod, with per-step timeout.
  Assumes the controller issues one go at a time and waits for done or timeout.
*/
`default_nettype none
module pdt_hs #(
  parameter int unsigned TO_CYC = pdt_pkg::HS_TIMEOUT_CYC
) (
  input wire logic clk_i,
  input wire logic arst_n_i,
  pdt_hs_if.eng hs,
  output logic cmd_req_o,
  output logic [7:0] cmd_byte_o,
  input wire logic cmd_ack_i,
  input wire logic rsp_req_i,
  input wire logic [7:0] rsp_byte_i,
  output logic rsp_ack_o
);
  import pdt_pkg::*;
  localparam int unsigned CW = $clog2(TO_CYC + 1);
  typedef enum logic [2:0] {H_IDLE, H_TX_ACK, H_TX_REL, H_RX_REQ, H_RX_REL} pdt_hst_t;
  pdt_hst_t st_q, st_d;
  logic [CW-1:0] cnt_q;
  logic [7:0] rx_q;
  logic expire_w;
  // ---------------------------------------------------------------
  // phase sequencing
  // ---------------------------------------------------------------
  assign expire_w = (st_q != H_IDLE) && (cnt_q == CW'(TO_CYC - 1));
  assign hs.timeout = expire_w;
  assign hs.done = ((st_q == H_TX_REL) && !cmd_ack_i) || ((st_q == H_RX_REL) && !rsp_req_i);
  assign hs.rx_byte = rx_q;
  assign cmd_req_o = (st_q == H_TX_ACK);
  assign rsp_ack_o = (st_q == H_RX_REL);
  always_comb begin
    st_d = st_q;
    unique case (st_q)
      H_IDLE: begin
        if (hs.tx_go) st_d = H_TX_ACK;
        else if (hs.rx_go) st_d = H_RX_REQ;
      end
      H_TX_ACK: if (cmd_ack_i) st_d = H_TX_REL;
      H_TX_REL: if (!cmd_ack_i) st_d = H_IDLE;
      H_RX_REQ: if (rsp_req_i) st_d = H_RX_REL;
      H_RX_REL: if (!rsp_req_i) st_d = H_IDLE;
    endcase
    if (expire_w || hs.abort) st_d = H_IDLE;
  end
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) st_q <= H_IDLE;
    else st_q <= st_d;
  end
  // count restarts on every phase change
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) cnt_q <= '0;
    else if (st_d != st_q || st_q == H_IDLE) cnt_q <= '0;
    else cnt_q <= cnt_q + 1'b1;
  end
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) cmd_byte_o <= 8'h00;
    else if (st_q == H_IDLE && hs.tx_go) cmd_byte_o <= hs.tx_byte;
  end
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) rx_q <= 8'h00;
    else if (st_q == H_RX_REQ && rsp_req_i) rx_q <= rsp_byte_i;
  end
  // ---------------------------------------------------------------
  // checks
  // ---------------------------------------------------------------
  cmd_hold_a: assert property (@(posedge clk_i) disable iff (!arst_n_i)
    cmd_req_o && !cmd_ack_i && !expire_w && !hs.abort |=> cmd_req_o && $stable(cmd_byte_o))
    else $error("command request dropped before ack");
  step_expire_a: assert property (@(posedge clk_i) disable iff (!arst_n_i)
    $rose(cmd_req_o) ##1 (!cmd_ack_i && !hs.abort) [*3] |-> !hs.timeout || TO_CYC <= 4)
    else $error("timeout fired too early");
endmodule
`default_nettype wire

/* verilog/pdt_ctrl.sv */
/*
  Operator parameter defaulting and pod command supervision with timeout and reset retry.
  Assumes keypad events arrive as one-cycle pulses synchronous to clk_i and the pod
  completes a four-phase handshake per byte.
*/
`default_nettype none
module pdt_ctrl #(
  parameter int unsigned HS_TO_CYC = pdt_pkg::HS_TIMEOUT_CYC,
  parameter int unsigned RST_CYC = pdt_pkg::RST_WAIT_CYC
) (
  input wire logic clk_i,
  input wire logic arst_n_i,
  input wire logic act_start_i,
  input wire pdt_pkg::pdt_act_t act_kind_i,
  input wire logic param_valid_i,
  input wire logic param_default_i,
  input wire logic [15:0] param_value_i,
  input wire logic desc_load_i,
  input wire logic [15:0] desc_first_i,
  input wire logic [15:0] desc_last_i,
  input wire logic [15:0] desc_sig_i,
  input wire logic target_power_ok_i,
  input wire logic pod_reset_done_i,
  output logic cmd_req_o,
  output logic [7:0] cmd_byte_o,
  input wire logic cmd_ack_i,
  input wire logic rsp_req_i,
  input wire logic [7:0] rsp_byte_i,
  output logic rsp_ack_o,
  output logic pod_reset_o,
  output logic prompt_o,
  output logic [1:0] prompt_index_o,
  output logic wait_o,
  output logic idle_o,
  output logic act_done_o,
  output logic fail_valid_o,
  output pdt_pkg::pdt_fail_t fail_type_o,
  output pdt_pkg::pdt_to_t timeout_code_o,
  output logic reset_attempt_o,
  output logic [15:0] result_o
);
  import pdt_pkg::*;
  localparam int unsigned RCW = $clog2(RST_CYC + 1);
  typedef enum logic [2:0] {S_IDLE, S_PROMPT, S_CMD, S_RSP, S_RESET, S_RWAIT} pdt_st_t;
  pdt_st_t st_q, st_d;
  pdt_act_t kind_q;
  logic [1:0] pidx_q;
  logic [2:0] bidx_q;
  logic iss_q;
  logic [RCW-1:0] rcnt_q;
  logic [15:0] addr_q, data_q, lasta_q, sig_q;
  logic [15:0] last_addr_q, wr_data_q;
  logic [15:0] dfirst_q, dlast_q, dsig_q;
  logic [7:0] status_q;
  logic [15:0] res_q;
  logic done_q, fail_q;
  pdt_fail_t fail_type_q;
  pdt_to_t to_code_q;
  pdt_hs_if hs ();

  // ---------------------------------------------------------------
  // prompt decode
  // ---------------------------------------------------------------
  logic take_w, dflt_w, sig_fill_w, last_param_w, go_w, start_ok_w;
  logic [1:0] nparam_w;
  logic [15:0] addr_pick_w, data_pick_w, sig_pick_w;
  assign start_ok_w = act_start_i && (st_q inside {S_IDLE, S_PROMPT, S_RESET, S_RWAIT});
  assign take_w = (st_q == S_PROMPT) && param_valid_i;
  assign dflt_w = take_w && param_default_i;
  assign sig_fill_w = dflt_w && (pidx_q == 2'h0) && (kind_q == PDT_ACT_SIG);
  assign nparam_w = (kind_q == PDT_ACT_READ) ? NPARAM_READ :
                    (kind_q == PDT_ACT_WRITE) ? NPARAM_WRITE : NPARAM_SIG;
  assign last_param_w = (pidx_q == nparam_w - 2'h1) || sig_fill_w;
  assign go_w = take_w && last_param_w;
  assign addr_pick_w = param_default_i ? last_addr_q : param_value_i;
  assign data_pick_w = param_default_i ? wr_data_q : param_value_i;
  assign sig_pick_w = param_default_i ? dsig_q : param_value_i;

  // ---------------------------------------------------------------
  // command and response sequencing
  // ---------------------------------------------------------------
  logic [2:0] cmd_len_w, rsp_len_w;
  logic [7:0] op_w;
  logic [15:0] p2_w;
  logic cmd_last_w, fin_w, to_w, sys_w, test_w, rexp_w;
  logic [7:0] status_fin_w;
  logic [15:0] res_fin_w;
  assign cmd_len_w = (kind_q == PDT_ACT_READ) ? CMD_LEN_SHORT : CMD_LEN_LONG;
  assign rsp_len_w = (kind_q == PDT_ACT_WRITE) ? RSP_LEN_SHORT : RSP_LEN_LONG;
  assign op_w = (kind_q == PDT_ACT_READ) ? OP_READ : (kind_q == PDT_ACT_WRITE) ? OP_WRITE : OP_SIG;
  assign p2_w = (kind_q == PDT_ACT_WRITE) ? data_q : lasta_q;
  assign hs.tx_byte = (bidx_q == 3'h0) ? op_w :
                      (bidx_q == 3'h1) ? addr_q[15:8] :
                      (bidx_q == 3'h2) ? addr_q[7:0] :
                      (bidx_q == 3'h3) ? p2_w[15:8] : p2_w[7:0];
  assign hs.tx_go = (st_q == S_CMD) && !iss_q;
  assign hs.rx_go = (st_q == S_RSP) && !iss_q;
  assign hs.abort = (st_q == S_RESET);
  assign cmd_last_w = (st_q == S_CMD) && hs.done && (bidx_q == cmd_len_w - 3'h1);
  assign fin_w = (st_q == S_RSP) && hs.done && (bidx_q == rsp_len_w - 3'h1);
  assign to_w = (st_q inside {S_CMD, S_RSP}) && hs.timeout;
  assign status_fin_w = (rsp_len_w == RSP_LEN_SHORT) ? hs.rx_byte : status_q;
  assign res_fin_w = {res_q[15:8], hs.rx_byte};
  assign sys_w = status_fin_w[ST_SYS_BIT];
  assign test_w = (kind_q == PDT_ACT_SIG) && (res_fin_w != sig_q);
  assign rexp_w = (st_q == S_RWAIT) && (rcnt_q == RCW'(RST_CYC - 1));

  // ---------------------------------------------------------------
  // main state
  // ---------------------------------------------------------------
  always_comb begin
    st_d = st_q;
    unique case (st_q)
      S_IDLE: if (start_ok_w) st_d = S_PROMPT;
      S_PROMPT: if (go_w) st_d = S_CMD;
      S_CMD: begin
        if (to_w) st_d = S_RESET;
        else if (cmd_last_w) st_d = S_RSP;
      end
      S_RSP: begin
        if (to_w) st_d = S_RESET;
        else if (fin_w) st_d = S_IDLE;
      end
      S_RESET: st_d = S_RWAIT;
      S_RWAIT: begin
        if (pod_reset_done_i) st_d = S_IDLE;
        else if (rexp_w) st_d = S_RESET;
      end
    endcase
    if (start_ok_w) st_d = S_PROMPT;
  end
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) st_q <= S_IDLE;
    else st_q <= st_d;
  end
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) kind_q <= PDT_ACT_READ;
    else if (start_ok_w) kind_q <= act_kind_i;
  end
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) pidx_q <= 2'h0;
    else if (start_ok_w) pidx_q <= 2'h0;
    else if (take_w) pidx_q <= pidx_q + 2'h1;
  end
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) bidx_q <= 3'h0;
    else if (go_w || cmd_last_w) bidx_q <= 3'h0;
    else if (hs.done) bidx_q <= bidx_q + 3'h1;
  end
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) iss_q <= 1'b0;
    else if (hs.tx_go || hs.rx_go) iss_q <= 1'b1;
    else if (hs.done || hs.timeout || st_q == S_RESET) iss_q <= 1'b0;
  end
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) rcnt_q <= '0;
    else if (st_q == S_RWAIT) rcnt_q <= rcnt_q + 1'b1;
    else rcnt_q <= '0;
  end

  // ---------------------------------------------------------------
  // parameter and default storage
  // ---------------------------------------------------------------
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      dfirst_q <= 16'h0000;
      dlast_q <= 16'h0000;
      dsig_q <= 16'h0000;
    end else if (desc_load_i) begin
      dfirst_q <= desc_first_i;
      dlast_q <= desc_last_i;
      dsig_q <= desc_sig_i;
    end
  end
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) addr_q <= 16'h0000;
    else if (sig_fill_w) addr_q <= dfirst_q;
    else if (take_w && pidx_q == 2'h0) addr_q <= addr_pick_w;
  end
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) lasta_q <= 16'h0000;
    else if (sig_fill_w) lasta_q <= dlast_q;
    else if (take_w && pidx_q == 2'h1 && kind_q == PDT_ACT_SIG) lasta_q <= addr_pick_w;
  end
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) sig_q <= 16'h0000;
    else if (sig_fill_w) sig_q <= dsig_q;
    else if (take_w && pidx_q == 2'h2) sig_q <= sig_pick_w;
  end
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) data_q <= 16'h0000;
    else if (take_w && pidx_q == 2'h1 && kind_q == PDT_ACT_WRITE) data_q <= data_pick_w;
  end
  // last address follows whatever address was specified or filled in
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) last_addr_q <= LAST_ADDR_RST;
    else if (sig_fill_w) last_addr_q <= dlast_q;
    else if (take_w && pidx_q == 2'h0) last_addr_q <= addr_pick_w;
    else if (take_w && pidx_q == 2'h1 && kind_q == PDT_ACT_SIG) last_addr_q <= addr_pick_w;
  end
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) wr_data_q <= WR_DATA_RST;
    else if (take_w && pidx_q == 2'h1 && kind_q == PDT_ACT_WRITE) wr_data_q <= data_pick_w;
  end

  // ---------------------------------------------------------------
  // response capture and failure classification
  // ---------------------------------------------------------------
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) status_q <= 8'h00;
    else if (st_q == S_RSP && hs.done && bidx_q == 3'h0) status_q <= hs.rx_byte;
  end
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) res_q <= 16'h0000;
    else if (st_q == S_RSP && hs.done && bidx_q == 3'h1) res_q[15:8] <= hs.rx_byte;
    else if (fin_w && rsp_len_w == RSP_LEN_LONG) res_q <= res_fin_w;
  end
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) fail_type_q <= PDT_FAIL_NONE;
    else if (start_ok_w) fail_type_q <= PDT_FAIL_NONE;
    else if (to_w) fail_type_q <= PDT_FAIL_TIMEOUT;
    else if (fin_w && sys_w) fail_type_q <= PDT_FAIL_SYSTEM;
    else if (fin_w && test_w) fail_type_q <= PDT_FAIL_TEST;
    else if (fin_w) fail_type_q <= PDT_FAIL_NONE;
  end
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) to_code_q <= PDT_TO_NONE;
    else if (start_ok_w) to_code_q <= PDT_TO_NONE;
    else if (to_w) to_code_q <= target_power_ok_i ? PDT_TO_POD : PDT_TO_POWER;
    else if (rexp_w && !pod_reset_done_i) to_code_q <= PDT_TO_RESET;
  end
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      fail_q <= 1'b0;
      done_q <= 1'b0;
    end else begin
      fail_q <= to_w || (fin_w && (sys_w || test_w));
      done_q <= fin_w;
    end
  end

  pdt_hs #(.TO_CYC(HS_TO_CYC)) u_hs (
    .clk_i(clk_i),
    .arst_n_i(arst_n_i),
    .hs(hs),
    .cmd_req_o(cmd_req_o),
    .cmd_byte_o(cmd_byte_o),
    .cmd_ack_i(cmd_ack_i),
    .rsp_req_i(rsp_req_i),
    .rsp_byte_i(rsp_byte_i),
    .rsp_ack_o(rsp_ack_o)
  );

  // ---------------------------------------------------------------
  // outputs
  // ---------------------------------------------------------------
  assign pod_reset_o = (st_q == S_RESET);
  assign reset_attempt_o = (st_q inside {S_RESET, S_RWAIT});
  assign wait_o = (st_q inside {S_CMD, S_RSP});
  assign idle_o = (st_q == S_IDLE);
  assign prompt_o = (st_q == S_PROMPT);
  assign prompt_index_o = pidx_q;
  assign act_done_o = done_q;
  assign fail_valid_o = fail_q;
  assign fail_type_o = fail_type_q;
  assign timeout_code_o = to_code_q;
  assign result_o = res_q;

  // ---------------------------------------------------------------
  // checks
  // ---------------------------------------------------------------
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!arst_n_i);
  default_addr_a: assert property (dflt_w && pidx_q == 2'h0 && kind_q != PDT_ACT_SIG |=>
    addr_q == $past(last_addr_q) && (kind_q != PDT_ACT_READ || st_q == S_CMD))
    else $error("defaulted address not taken from last address");
  default_data_a: assert property (dflt_w && pidx_q == 2'h1 && kind_q == PDT_ACT_WRITE |=>
    data_q == $past(wr_data_q) && wait_o)
    else $error("defaulted write data not reused");
  desc_fill_a: assert property (sig_fill_w && !start_ok_w |=>
    st_q == S_CMD && addr_q == $past(dfirst_q) && lasta_q == $past(dlast_q) && sig_q == $past(dsig_q))
    else $error("descriptors not filled in");
  fail_class_a: assert property (fail_valid_o |->
    fail_type_o inside {PDT_FAIL_TIMEOUT, PDT_FAIL_SYSTEM, PDT_FAIL_TEST})
    else $error("failure without a class");
  cmd_then_rsp_a: assert property (cmd_last_w && !start_ok_w |=> st_q == S_RSP && bidx_q == 3'h0)
    else $error("response phase not entered after command");
  to_code_a: assert property (to_w && !target_power_ok_i |=>
    timeout_code_o == PDT_TO_POWER && reset_attempt_o && fail_type_o == PDT_FAIL_TIMEOUT)
    else $error("power timeout code missing");
  to_reset_a: assert property (to_w && !start_ok_w |=> pod_reset_o ##1 !pod_reset_o && reset_attempt_o)
    else $error("timeout did not reset pod");
  reset_retry_a: assert property (rexp_w && !pod_reset_done_i && !act_start_i |=>
    pod_reset_o && timeout_code_o == PDT_TO_RESET)
    else $error("pod reset not retried");
  wait_idle_a: assert property (fin_w && !start_ok_w |=> idle_o && !wait_o && act_done_o)
    else $error("idle not reached after action");
endmodule
`default_nettype wire

/* bench/pdt_pod_model.sv */
/*
  Pod model: four-phase byte handshake, answers each command with status, plus data for reads and signatures.
  Assumes the controller drives its link outputs from clk_i flops.
*/
`default_nettype none
module pdt_pod_model (
  input wire logic clk_i,
  input wire logic cmd_req_i,
  input wire logic [7:0] cmd_byte_i,
  output logic cmd_ack_o,
  output logic rsp_req_o,
  output logic [7:0] rsp_byte_o,
  input wire logic rsp_ack_i,
  input wire logic mute_i,
  input wire logic [3:0] dly_i,
  input wire logic [7:0] sts_i,
  input wire logic [15:0] val_i,
  output logic [39:0] log_o
);
  timeunit 1ns;
  timeprecision 1ns;
  import pdt_pkg::*;
  logic [7:0] op;
  logic [23:0] rsp;
  int n;
  initial begin
    cmd_ack_o = 1'b0;
    rsp_req_o = 1'b0;
    rsp_byte_o = 8'h00;
    log_o = '0;
    n = 0;
    op = 8'h00;
    forever begin
      @(posedge clk_i iff (cmd_req_i && !mute_i));
      repeat (dly_i) @(posedge clk_i);
      if (n == 0) op = cmd_byte_i;
      log_o = {log_o[31:0], cmd_byte_i};
      n++;
      #1 cmd_ack_o = 1'b1;
      @(posedge clk_i iff !cmd_req_i);
      #1 cmd_ack_o = 1'b0;
      if (n == ((op == OP_READ) ? 3 : 5)) begin
        n = 0;
        rsp = {sts_i, val_i};
        for (int i = 0; i < ((op == OP_WRITE) ? 1 : 3); i++) begin
          @(posedge clk_i);
          #1 rsp_req_o = 1'b1;
          rsp_byte_o = rsp[23:16];
          @(posedge clk_i iff rsp_ack_i);
          #1 rsp_req_o = 1'b0;
          // released line shows the inverse, not the old byte
          rsp_byte_o = ~rsp[23:16];
          rsp = rsp << 8;
          @(posedge clk_i iff !rsp_ack_i);
        end
      end
    end
  end
endmodule
`default_nettype wire

/* bench/tb.sv */
/*
  Testbench for pdt_ctrl: operator defaults, pod exchange, failures, timeout and reset retry.
  Assumes the pod model in pdt_pod_model and short counts set at the instance.
*/
`default_nettype none
module tb;
  timeunit 1ns;
  timeprecision 1ns;
  import pdt_pkg::*;
  logic clk_i = 1'b0, arst_n_i = 1'b0, act_start = 1'b0, param_valid = 1'b0, param_default = 1'b0;
  logic desc_load = 1'b0, power_ok = 1'b1, reset_done = 1'b0, mute = 1'b0;
  logic [15:0] param_value = 16'h0000, val = 16'h0000, result;
  logic [7:0] sts = 8'h00, cmd_byte, rsp_byte;
  logic [3:0] dly = 4'h0;
  logic [39:0] log;
  logic cmd_req, cmd_ack, rsp_req, rsp_ack, pod_reset, prompt, busy, idle, act_done, fail_valid, reset_attempt;
  logic [1:0] prompt_index;
  pdt_act_t act_kind = PDT_ACT_READ;
  pdt_fail_t fail_type;
  pdt_to_t to_code;
  int failures = 0, checked = 0;
  always #20 clk_i = ~clk_i;
  pdt_ctrl #(.HS_TO_CYC(16), .RST_CYC(8)) dut (.clk_i(clk_i), .arst_n_i(arst_n_i), .act_start_i(act_start),
    .act_kind_i(act_kind), .param_valid_i(param_valid), .param_default_i(param_default),
    .param_value_i(param_value), .desc_load_i(desc_load), .desc_first_i(16'h2000), .desc_last_i(16'h3FFF),
    .desc_sig_i(16'h25DA), .target_power_ok_i(power_ok), .pod_reset_done_i(reset_done), .cmd_req_o(cmd_req),
    .cmd_byte_o(cmd_byte), .cmd_ack_i(cmd_ack), .rsp_req_i(rsp_req), .rsp_byte_i(rsp_byte), .rsp_ack_o(rsp_ack),
    .pod_reset_o(pod_reset), .prompt_o(prompt), .prompt_index_o(prompt_index), .wait_o(busy), .idle_o(idle),
    .act_done_o(act_done), .fail_valid_o(fail_valid), .fail_type_o(fail_type), .timeout_code_o(to_code),
    .reset_attempt_o(reset_attempt), .result_o(result));
  pdt_pod_model pod (.clk_i(clk_i), .cmd_req_i(cmd_req), .cmd_byte_i(cmd_byte), .cmd_ack_o(cmd_ack),
    .rsp_req_o(rsp_req), .rsp_byte_o(rsp_byte), .rsp_ack_i(rsp_ack), .mute_i(mute), .dly_i(dly),
    .sts_i(sts), .val_i(val), .log_o(log));
  task automatic chk(input string nm, input logic [39:0] seen, input logic [39:0] exp);
    checked++;
    if (seen !== exp) begin
      failures++;
      $display("[ERR] %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  // one action: key, parameters (dm bit set = defaulted), wait for done or fail
  task automatic run(input pdt_act_t k, input logic [2:0] dm, input logic [47:0] p);
    int np;
    logic saw;
    np = (k == PDT_ACT_READ) ? 1 : (k == PDT_ACT_WRITE) ? 2 : (dm[0] ? 1 : 3);
    saw = 1'b0;
    @(posedge clk_i);
    #1 act_start = 1'b1;
    act_kind = k;
    @(posedge clk_i);
    #1 act_start = 1'b0;
    for (int i = 0; i < np; i++) begin
      chk("prompt", {prompt, prompt_index}, {1'b1, 2'(i)});
      param_valid = 1'b1;
      param_default = dm[i];
      param_value = p[47-16*i -: 16];
      @(posedge clk_i);
      #1;
    end
    param_valid = 1'b0;
    for (int i = 0; i < 400 && act_done !== 1'b1 && fail_valid !== 1'b1; i++) begin
      saw |= (busy === 1'b1);
      @(posedge clk_i);
      #1;
    end
    chk("busy_seen", saw, 1'b1);
  endtask
  task automatic t_read();
    val = 16'h1234;
    run(PDT_ACT_READ, 3'b000, {16'h40FF, 32'h0});
    chk("rd_cmd", log[23:0], 24'h0140FF);
    chk("rd_result", result, 16'h1234);
    chk("rd_fail", fail_type, PDT_FAIL_NONE);
    run(PDT_ACT_READ, 3'b001, 48'h0);
    chk("rd_def_cmd", log[23:0], 24'h0140FF);
    chk("rd_done", act_done, 1'b1);
    @(posedge clk_i);
    #1 chk("rd_idle", {idle, busy}, 2'b10);
  endtask
  task automatic t_write();
    run(PDT_ACT_WRITE, 3'b000, {16'h20F0, 16'h7AB3, 16'h0});
    chk("wr_cmd", log, 40'h0220F07AB3);
    sts = 8'h01;
    dly = 4'hC;
    run(PDT_ACT_WRITE, 3'b010, {16'h38C6, 32'h0});
    chk("wr_def_cmd", log, 40'h0238C67AB3);
    chk("wr_slow_sys", fail_type, PDT_FAIL_SYSTEM);
    sts = 8'h00;
    dly = 4'h0;
  endtask
  task automatic t_sig();
    @(posedge clk_i);
    #1 desc_load = 1'b1;
    @(posedge clk_i);
    #1 desc_load = 1'b0;
    val = 16'h25DA;
    run(PDT_ACT_SIG, 3'b001, 48'h0);
    chk("sig_def_cmd", log, 40'h0320003FFF);
    chk("sig_pass", fail_type, PDT_FAIL_NONE);
    val = 16'h2222;
    run(PDT_ACT_SIG, 3'b000, {16'h1000, 16'h1FFF, 16'h1111});
    chk("sig_cmd", log, 40'h0310001FFF);
    chk("sig_test", fail_type, PDT_FAIL_TEST);
    run(PDT_ACT_READ, 3'b001, 48'h0);
    chk("last_addr", log[23:0], 24'h011FFF);
  endtask
  task automatic t_timeout();
    mute = 1'b1;
    run(PDT_ACT_READ, 3'b001, 48'h0);
    chk("to_fail", {fail_valid, fail_type}, {1'b1, PDT_FAIL_TIMEOUT});
    chk("to_pod", {to_code, reset_attempt, busy}, {PDT_TO_POD, 2'b10});
    chk("to_rst", pod_reset, 1'b1);
    for (int i = 0; i < 20; i++) begin
      @(posedge clk_i);
      #1 if (pod_reset === 1'b1) break;
    end
    chk("retry_rst", {pod_reset, to_code, reset_attempt}, {1'b1, PDT_TO_RESET, 1'b1});
    reset_done = 1'b1;
    repeat (2) @(posedge clk_i);
    #1 chk("rst_ok", {idle, reset_attempt}, 2'b10);
    reset_done = 1'b0;
    power_ok = 1'b0;
    run(PDT_ACT_READ, 3'b001, 48'h0);
    chk("to_power", to_code, PDT_TO_POWER);
    mute = 1'b0;
    power_ok = 1'b1;
    run(PDT_ACT_READ, 3'b001, 48'h0);
    chk("new_act", {fail_type, to_code, act_done}, {PDT_FAIL_NONE, PDT_TO_NONE, 1'b1});
  endtask
  task automatic end_sim();
    $display("checked %0d failures %0d", checked, failures);
    if (failures == 0 && checked > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask
  initial begin
    repeat (3) @(posedge clk_i);
    #1 arst_n_i = 1'b1;
    chk("rst_state", {idle, busy, fail_type}, {2'b10, PDT_FAIL_NONE});
    t_read();
    t_write();
    t_sig();
    t_timeout();
    end_sim();
  end
  initial begin
    #(40 * 6000);
    failures++;
    end_sim();
  end
endmodule
`default_nettype wire
